// ===== shared/irq_encoder_defines.vh
// Constants for the interrupt address encoder
// Notes on behaviour
// - Interrupt at T5 when flag and enable
// - Service address equals requester select code
// - Address on transfer bus only phase4 T7
// - Address bits 5:4 encode active group
// - Address bits 3:0 encode active request line
// - Run output is inverted run flop two
// - Capture address into register at phase4 T7
// - Read register on group B, code 04, strobe
// - Select code split into one-hot octal digits
`ifndef IRQ_ENCODER_DEFINES_VH
`define IRQ_ENCODER_DEFINES_VH
`define ADDR_W        6
`define GROUP_N       4
`define REQ_N         16
`define DIGIT_N       8
`define DIGIT_LO      2:0
`define DIGIT_HI      5:3
`define ADDR_GROUP    5:4
`define ADDR_INDEX    3:0
`define GROUP_CODE_W  2
`define INDEX_W       4
`define LAST_SRC_MSD  3'h0
`define LAST_SRC_LSD  3'h4
`define LAST_SRC_OFS  6'h04
`define LAST_SRC_RST  6'h00
`endif

// ===== hdl/onehot_encoder.v
// One-hot to binary encoder
`timescale 1ns/1ns
`default_nettype none
module onehot_encoder #(
	parameter N = 16,
	parameter W = 4
) (
	input  wire [N-1:0] onehot,
	output reg  [W-1:0] code
);
	integer i;
	always @* begin
		code = {W{1'b0}};
		for (i = 0; i < N; i = i + 1) begin
			if (onehot[i]) begin
				code = code | i[W-1:0];
			end
		end
	end
endmodule
`default_nettype wire

// ===== hdl/interrupt_address_encoder.v
// Interrupt request encoder, last-source register and run line
`timescale 1ns/1ns
`default_nettype none
`include "irq_encoder_defines.vh"
module interrupt_address_encoder #(
	parameter ADDR_W  = `ADDR_W,
	parameter GROUP_N = `GROUP_N,
	parameter REQ_N   = `REQ_N,
	parameter DIGIT_N = `DIGIT_N
) (
	input  wire               clock,
	input  wire               srst,
	input  wire [GROUP_N-1:0] group_request_flag,
	input  wire [REQ_N-1:0]   request_line,
	input  wire               service_request_enable,
	input  wire               t5_strobe,
	input  wire               phase4_t7_strobe,
	input  wire               run_flop_two_low,
	input  wire [ADDR_W-1:0]  select_code,
	input  wire               io_address_enable,
	input  wire               io_group_b,
	input  wire               io_input_strobe,
	output reg                interrupt_q,
	output reg  [ADDR_W-1:0]  transfer_bus_q,
	output reg  [DIGIT_N-1:0] select_high_digit,
	output reg  [DIGIT_N-1:0] select_low_digit,
	output reg  [ADDR_W-1:0]  processor_input_bus_q,
	output reg                run_q
);

	// Next values of the registered outputs
	reg                      interrupt_d;
	reg  [ADDR_W-1:0]        transfer_bus_d;
	reg  [ADDR_W-1:0]        processor_input_bus_d;
	reg                      run_d;

	// Last interrupting source and its next value
	reg  [ADDR_W-1:0]        last_source_q;
	reg  [ADDR_W-1:0]        last_source_d;

	// Encoder results and qualifiers
	wire [`GROUP_CODE_W-1:0] group_code;
	wire [`INDEX_W-1:0]      index_code;
	wire [ADDR_W-1:0]        service_addr;
	wire                     any_group_flag;
	wire                     read_last_source;

	// Group number from the four group flags
	onehot_encoder #(
		.N (GROUP_N),
		.W (`GROUP_CODE_W)
	) u_group (
		.onehot (group_request_flag),
		.code   (group_code)
	);

	// Position of the requester within its group
	onehot_encoder #(
		.N (REQ_N),
		.W (`INDEX_W)
	) u_index (
		.onehot (request_line),
		.code   (index_code)
	);

	// Select code of the single requester
	// Two requesters at once would merge their codes
	assign service_addr = {group_code, index_code};

	// Any group asking for service
	assign any_group_flag = |group_request_flag;

	// High octal digit, off while addresses are disabled
	always @* begin
		select_high_digit = {DIGIT_N{1'b0}};
		if (io_address_enable) begin
			case (select_code[`DIGIT_HI])
				3'h0: select_high_digit[0] = 1'b1;
				3'h1: select_high_digit[1] = 1'b1;
				3'h2: select_high_digit[2] = 1'b1;
				3'h3: select_high_digit[3] = 1'b1;
				3'h4: select_high_digit[4] = 1'b1;
				3'h5: select_high_digit[5] = 1'b1;
				3'h6: select_high_digit[6] = 1'b1;
				default: select_high_digit[7] = 1'b1;
			endcase
		end
	end

	// Low octal digit, off while addresses are disabled
	always @* begin
		select_low_digit = {DIGIT_N{1'b0}};
		if (io_address_enable) begin
			case (select_code[`DIGIT_LO])
				3'h0: select_low_digit[0] = 1'b1;
				3'h1: select_low_digit[1] = 1'b1;
				3'h2: select_low_digit[2] = 1'b1;
				3'h3: select_low_digit[3] = 1'b1;
				3'h4: select_low_digit[4] = 1'b1;
				3'h5: select_low_digit[5] = 1'b1;
				3'h6: select_low_digit[6] = 1'b1;
				default: select_low_digit[7] = 1'b1;
			endcase
		end
	end

	// Register read needs group B, both digits and the strobe
	assign read_last_source = io_group_b
		&& io_input_strobe
		&& select_high_digit[`LAST_SRC_MSD]
		&& select_low_digit[`LAST_SRC_LSD];

	// Interrupt only changes in the T5 slot
	always @* begin
		interrupt_d = interrupt_q;
		if (t5_strobe) begin
			interrupt_d = any_group_flag && service_request_enable;
		end
	end

	// Service address shown for one cycle after phase 4 T7
	always @* begin
		transfer_bus_d = {ADDR_W{1'b0}};
		if (phase4_t7_strobe) begin
			transfer_bus_d = service_addr;
		end
	end

	// Last source is overwritten on every interrupt phase
	always @* begin
		last_source_d = last_source_q;
		if (phase4_t7_strobe) begin
			last_source_d = service_addr;
		end
	end

	// Input bus stays zero unless the register is read
	always @* begin
		processor_input_bus_d = {ADDR_W{1'b0}};
		if (read_last_source) begin
			processor_input_bus_d = last_source_q;
		end
	end

	// Run line is the inverse of the halted level
	always @* begin
		run_d = ~run_flop_two_low;
	end

	// Interrupt request flop
	always @(posedge clock) begin
		if (srst) begin
			interrupt_q <= 1'b0;
		end else begin
			interrupt_q <= interrupt_d;
		end
	end

	// Transfer bus driver
	always @(posedge clock) begin
		if (srst) begin
			transfer_bus_q <= {ADDR_W{1'b0}};
		end else begin
			transfer_bus_q <= transfer_bus_d;
		end
	end

	// Last interrupting source register
	always @(posedge clock) begin
		if (srst) begin
			last_source_q <= `LAST_SRC_RST;
		end else begin
			last_source_q <= last_source_d;
		end
	end

	// Contribution to the processor input bus
	always @(posedge clock) begin
		if (srst) begin
			processor_input_bus_q <= {ADDR_W{1'b0}};
		end else begin
			processor_input_bus_q <= processor_input_bus_d;
		end
	end

	// Run line to the interface slots
	always @(posedge clock) begin
		if (srst) begin
			run_q <= 1'b0;
		end else begin
			run_q <= run_d;
		end
	end

endmodule
`default_nettype wire

// ===== testbench/iae_monitor.sv
// Checker for the interrupt address encoder
`timescale 1ns/1ns
`default_nettype none
module iae_monitor(input wire logic clock, srst, t5_strobe, phase4_t7_strobe, interrupt_q, run_q,
	service_request_enable, run_flop_two_low, io_group_b, io_input_strobe, io_address_enable,
	input wire logic [3:0] group_request_flag, input wire logic [5:0] select_code,
	transfer_bus_q, processor_input_bus_q);
	wire rd = io_group_b && io_input_strobe && io_address_enable && select_code == 6'h04;
	sequence cap_rd; phase4_t7_strobe ##1 rd; endsequence
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	irq_on_a: assert property (t5_strobe && service_request_enable |=>
		interrupt_q == $past(|group_request_flag)) else $error("irq set");
	irq_off_a: assert property (t5_strobe && !service_request_enable |=> !interrupt_q)
		else $error("irq off");
	irq_hold_a: assert property (!t5_strobe |=> $stable(interrupt_q)) else $error("irq");
	bus_t7_a: assert property (!phase4_t7_strobe |=> !transfer_bus_q) else $error("bus");
	grp_code_a: assert property (phase4_t7_strobe && group_request_flag[2] |=> transfer_bus_q[5])
		else $error("group");
	run_line_a: assert property (1 |=> run_q == !$past(run_flop_two_low)) else $error("run");
	reg_read_a: assert property (cap_rd |=> processor_input_bus_q == $past(transfer_bus_q))
		else $error("read");
	bus_quiet_a: assert property (!rd |=> !processor_input_bus_q) else $error("quiet");
endmodule
bind interrupt_address_encoder iae_monitor i_mon(.*);
`default_nettype wire

// ===== testbench/cpu_slot.sv
// Processor slot timing and interrupt phase entry
`timescale 1ns/1ns
`default_nettype none
module cpu_slot(input wire logic clock, interrupt_q, output wire logic t5_strobe, phase4_t7_strobe);
	logic [2:0] slot = 3'h0; logic ph4 = 1'b0;
	always @(negedge clock) begin slot <= slot + 3'h1; if (slot == 3'h7) ph4 <= interrupt_q; end
	assign t5_strobe = slot == 3'h5;
	assign phase4_t7_strobe = ph4 && slot == 3'h7;
endmodule
`default_nettype wire

// ===== testbench/test_interrupt_address_encoder.sv
// Self-checking bench for the interrupt address encoder
`timescale 1ns/1ns
`default_nettype none
module test_interrupt_address_encoder;
	logic clock = 0, srst = 1, service_request_enable = 0, run_flop_two_low = 0, io_group_b = 0;
	logic io_input_strobe = 0, io_address_enable = 1;
	logic [5:0] select_code = 6'h04;
	logic [3:0] group_request_flag = 4'h0; logic [15:0] request_line = 16'h0000;
	// Rows: group flags, request lines, expected address; one requester each
	logic [25:0] rows [4] = '{{4'h1, 16'h0080, 6'h07}, {4'h2, 16'h0400, 6'h1A},
		{4'h4, 16'h0008, 6'h23}, {4'h8, 16'h4000, 6'h3E}};
	wire t5_strobe, phase4_t7_strobe, interrupt_q, run_q;
	wire [5:0] transfer_bus_q, processor_input_bus_q;
	wire [7:0] select_high_digit, select_low_digit;
	int n_fail = 0, samples_checked = 0;
	always #50 clock = ~clock;
	cpu_slot i_cpu(.*);
	interrupt_address_encoder i_dut(.*);
	task automatic chk(input string name, input logic [7:0] s, e);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", name, e, s);
		end
	endtask
	task test_done;
		if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic rd(input logic g, s, a, input logic [5:0] c);
		io_group_b = g;
		io_input_strobe = s;
		io_address_enable = a;
		select_code = c;
		@(negedge clock);
	endtask
	initial begin
		#200000;
		n_fail++;
		test_done;
	end
	initial begin
		repeat (4) @(negedge clock);
		srst = 0;
		service_request_enable = 1;
		foreach (rows[i]) begin
			{group_request_flag, request_line} = rows[i][25:6];
			run_flop_two_low = i[0];
			for (int w = 0; w < 40 && transfer_bus_q === 6'h00; w++) @(negedge clock);
			chk("addr", transfer_bus_q, rows[i][5:0]);
			chk("irq", interrupt_q, 8'h01);
			chk("run", run_q, !i[0]);
			rd(1, 1, 1, 6'h04);
			chk("read", processor_input_bus_q, rows[i][5:0]);
			chk("addr off", transfer_bus_q, 8'h00);
			rd(0, 0, 1, 6'h04);
			chk("bus idle", processor_input_bus_q, 8'h00);
		end
		rd(1, 0, 1, 6'h04);
		chk("no strobe", processor_input_bus_q, 8'h00);
		rd(0, 1, 1, 6'h04);
		chk("no group b", processor_input_bus_q, 8'h00);
		rd(1, 1, 1, 6'h05);
		chk("code 05", processor_input_bus_q, 8'h00);
		chk("high digit", select_high_digit, 8'h01);
		chk("low digit", select_low_digit, 8'h20);
		rd(1, 1, 0, 6'h04);
		chk("addr off rd", processor_input_bus_q, 8'h00);
		chk("digits off", select_high_digit | select_low_digit, 8'h00);
		rd(1, 1, 1, 6'h04);
		chk("reread", processor_input_bus_q, 8'h3E);
		rd(0, 0, 1, 6'h04);
		group_request_flag = 4'h0;
		request_line = 16'h0000;
		repeat (10) @(negedge clock);
		chk("no flag", interrupt_q, 8'h00);
		{group_request_flag, request_line} = rows[1][25:6];
		repeat (10) @(negedge clock);
		chk("irq again", interrupt_q, 8'h01);
		srst = 1;
		@(negedge clock);
		chk("rst irq", interrupt_q, 8'h00);
		chk("rst run", run_q, 8'h00);
		chk("rst bus", transfer_bus_q, 8'h00);
		srst = 0;
		rd(1, 1, 1, 6'h04);
		chk("rst reg", processor_input_bus_q, 8'h00);
		rd(0, 0, 1, 6'h04);
		service_request_enable = 0;
		repeat (20) @(negedge clock);
		chk("irq off", interrupt_q, 8'h00);
		test_done;
	end
endmodule
`default_nettype wire
